//--- hasp_pkg.sv
// Functional notes
// - rx config write: 80ns irq, 60ns status
// - power write: 165 self, 170 irq, 160 status
// - timer config write: 55 self, 170 count
// - ptp command write: 70 irq, 50 statuses
// - ptp status write: 60ns before irq read
// - ptp enable write: 60ns before irq read
// - pin event write: 60ns before irq read
// - read pairs keep their own minimum wait
// - probe reads may fill any wait
// - wait arms only after dword-completing access
// - rx data pop: 135ns before rx info
// - rx status pop: 135ns before rx info
// - tx status pop: 135ns before tx info
// - drop counter read: 180ns before reread
// - any write: 45ns before rereading it
package hasp_pkg;
   // reference clock period
   localparam int CLK_NS = 10;
   // bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int GAP_W  = 8;
   // saturation value of the elapsed counter
   localparam logic [GAP_W-1:0] GAP_MAX = 8'hff;
   // byte-order probe register address
   localparam logic [ADDR_W-1:0] PROBE_ADDR = 16'h00fc;
   // strobe length of one bus access
   localparam int STROBE_NS = 40;
   localparam logic [2:0] STROBE_CYC = 3'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   // minimum waits in ns, as given
   localparam int RXCFG_IRQ_NS  = 80;
   localparam int RXCFG_TOP_NS  = 60;
   localparam int PWR_SELF_NS   = 165;
   localparam int PWR_IRQ_NS    = 170;
   localparam int PWR_TOP_NS    = 160;
   localparam int GPT_SELF_NS   = 55;
   localparam int GP_TIMER_COUNT_REG_NS    = 170;
   localparam int PTP_IRQ_NS    = 70;
   localparam int PTP_STS_NS    = 50;
   localparam int PTP_EVT_NS    = 60;
   localparam int QUEUE_NS      = 135;
   localparam int DROP_NS       = 180;
   localparam int ANY_WR_NS     = 45;
   // minimum waits in whole cycles, rounded up
   localparam logic [GAP_W-1:0] RXCFG_IRQ_CYC = 8'((RXCFG_IRQ_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] RXCFG_TOP_CYC = 8'((RXCFG_TOP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] PWR_SELF_CYC  = 8'((PWR_SELF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] PWR_IRQ_CYC   = 8'((PWR_IRQ_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] PWR_TOP_CYC   = 8'((PWR_TOP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] GPT_SELF_CYC  = 8'((GPT_SELF_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] GP_TIMER_COUNT_REG_CYC   = 8'((GP_TIMER_COUNT_REG_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] PTP_IRQ_CYC   = 8'((PTP_IRQ_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] PTP_STS_CYC   = 8'((PTP_STS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] PTP_EVT_CYC   = 8'((PTP_EVT_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] QUEUE_CYC     = 8'((QUEUE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] DROP_CYC      = 8'((DROP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [GAP_W-1:0] ANY_WR_CYC    = 8'((ANY_WR_NS + CLK_NS - 1) / CLK_NS);
   // resource classes that the spacing depends on
   typedef enum logic [4:0] {
      RES_OTHER, RES_RX_CFG, RES_IRQ_CFG, RES_TOP_STS, RES_PWR_CTRL,
      RES_GP_TIMER_CONFIG_REG, RES_GP_TIMER_COUNT_REG, RES_PTP_CMD, RES_PTP_STS, RES_PTP_EN,
      RES_PIN_EVT, RES_RX_DATA, RES_RX_STS, RES_TX_STS, RES_RX_QINFO,
      RES_TX_QINFO, RES_RX_DROP
   } hasp_res_t;
endpackage

//--- hasp_gap_if.sv
`timescale 1ns/1ps
// previous and next access, and the wait that the pair needs
interface hasp_gap_if;
   import hasp_pkg::*;
   logic                    prev_valid; // a completed access is on record
   logic                    prev_write; // that access was a write
   hasp_res_t               prev_res;   // its resource class
   logic                    same_addr;  // next access hits the same address
   logic                    next_write; // next access is a write
   hasp_res_t               next_res;   // next resource class
   logic [GAP_W-1:0]        gap_cyc;    // cycles needed before next read
   modport seq (output prev_valid, prev_write, prev_res, same_addr, next_write, next_res,
                input gap_cyc);
   modport lookup (input prev_valid, prev_write, prev_res, same_addr, next_write, next_res,
                   output gap_cyc);
endinterface

//--- hasp_gap_lookup.sv
`timescale 1ns/1ps
// pair table: cycles to hold a read after the last completed access
module hasp_gap_lookup (
   // pair under test
   hasp_gap_if.lookup g
);
   import hasp_pkg::*;

   // wait for one specific pair, zero when the pair is free
   function automatic logic [GAP_W-1:0] pair_gap(input logic pw, input hasp_res_t pr,
                                                 input hasp_res_t nr);
      logic [GAP_W-1:0] v;
      v = '0;
      if (pw) begin
         unique case (pr)
            RES_RX_CFG: begin
               if (nr == RES_IRQ_CFG) v = RXCFG_IRQ_CYC;
               if (nr == RES_TOP_STS) v = RXCFG_TOP_CYC;
            end
            RES_PWR_CTRL: begin
               if (nr == RES_PWR_CTRL) v = PWR_SELF_CYC;
               if (nr == RES_IRQ_CFG) v = PWR_IRQ_CYC;
               if (nr == RES_TOP_STS) v = PWR_TOP_CYC;
            end
            RES_GP_TIMER_CONFIG_REG: begin
               if (nr == RES_GP_TIMER_CONFIG_REG) v = GPT_SELF_CYC;
               if (nr == RES_GP_TIMER_COUNT_REG) v = GP_TIMER_COUNT_REG_CYC;
            end
            RES_PTP_CMD: begin
               if (nr == RES_IRQ_CFG) v = PTP_IRQ_CYC;
               if (nr == RES_TOP_STS || nr == RES_PTP_STS) v = PTP_STS_CYC;
            end
            // status, enable and pin event writes all gate the irq line
            RES_PTP_STS, RES_PTP_EN, RES_PIN_EVT: begin
               if (nr == RES_IRQ_CFG) v = PTP_EVT_CYC;
            end
            default: v = '0;
         endcase
      end else begin
         unique case (pr)
            // fifo pops take time to show in the queue info registers
            RES_RX_DATA, RES_RX_STS: begin
               if (nr == RES_RX_QINFO) v = QUEUE_CYC;
            end
            RES_TX_STS: begin
               if (nr == RES_TX_QINFO) v = QUEUE_CYC;
            end
            RES_RX_DROP: begin
               if (nr == RES_RX_DROP) v = DROP_CYC;
            end
            default: v = '0;
         endcase
      end
      return v;
   endfunction

   // worst of the pair wait and the same-address write floor
   always_comb begin
      logic [GAP_W-1:0] p;
      p = pair_gap(g.prev_write, g.prev_res, g.next_res);
      g.gap_cyc = '0;
      if (g.prev_valid && !g.next_write) begin
         g.gap_cyc = p;
         if (g.prev_write && g.same_addr && p < ANY_WR_CYC) begin
            g.gap_cyc = ANY_WR_CYC;
         end
      end
   end
endmodule

//--- hasp_seq.sv
`timescale 1ns/1ps
// host access sequencer: runs client accesses on the device bus and
// holds each read back until the wait since the last access is met
module hasp_seq (
   // clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_reset_n,
   // client request
   input  wire logic                          i_req_valid,
   input  wire logic                          i_req_write,
   input  wire logic                          i_req_last,
   input  wire hasp_pkg::hasp_res_t           i_req_res,
   input  wire logic [hasp_pkg::ADDR_W-1:0]   i_req_addr,
   input  wire logic [hasp_pkg::DATA_W-1:0]   i_req_wdata,
   input  wire logic                          i_probe_mode,
   output logic                               o_req_ready,
   // client answer
   output logic                               o_resp_valid,
   output logic [hasp_pkg::DATA_W-1:0]        o_resp_data,
   // device bus pins
   output logic                               o_bus_cs_n,
   output logic                               o_bus_rd_n,
   output logic                               o_bus_wr_n,
   output logic [hasp_pkg::ADDR_W-1:0]        o_bus_addr,
   input  wire logic [hasp_pkg::DATA_W-1:0]   i_bus_data,
   output logic [hasp_pkg::DATA_W-1:0]        o_bus_data,
   output logic                               o_bus_data_oe_n
);
   import hasp_pkg::*;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_STROBE, ST_RECOVER
   } hasp_state_t;

   hasp_state_t               state_reg, state_next;       // sequencer state
   logic [2:0]                strobe_reg, strobe_next;     // cycles into strobe
   logic                      probe_reg, probe_next;       // strobe is a dummy probe read
   // current request
   logic                      cur_write_reg, cur_write_next;
   logic                      cur_last_reg, cur_last_next;
   hasp_res_t                 cur_res_reg, cur_res_next;
   logic [ADDR_W-1:0]         cur_addr_reg, cur_addr_next;
   logic [DATA_W-1:0]         cur_wdata_reg, cur_wdata_next;
   // last completed access
   logic                      prev_valid_reg, prev_valid_next;
   logic                      prev_write_reg, prev_write_next;
   hasp_res_t                 prev_res_reg, prev_res_next;
   logic [ADDR_W-1:0]         prev_addr_reg, prev_addr_next;
   logic [GAP_W-1:0]          elapsed_reg, elapsed_next;   // cycles since last completing access ended
   // pin and client outputs
   logic                      ready_reg, ready_next;
   logic                      resp_valid_reg, resp_valid_next;
   logic [DATA_W-1:0]         resp_data_reg, resp_data_next;
   logic                      cs_n_reg, cs_n_next;
   logic                      rd_n_reg, rd_n_next;
   logic                      wr_n_reg, wr_n_next;
   logic [ADDR_W-1:0]         addr_reg, addr_next;
   logic [DATA_W-1:0]         wdata_reg, wdata_next;
   logic                      oe_n_reg, oe_n_next;
   // read data synchroniser
   logic [DATA_W-1:0]         rd_sync1_reg, rd_sync2_reg;
   // decode helpers
   logic                      gap_ok;                      // wait before this read is met
   logic                      launch_rd;                   // real read strobe starts next
   logic                      strobe_end;                  // last strobe cycle

   // pair lookup
   hasp_gap_if gap_bus ();

   assign gap_bus.prev_valid = prev_valid_reg;
   assign gap_bus.prev_write = prev_write_reg;
   assign gap_bus.prev_res   = prev_res_reg;
   assign gap_bus.same_addr  = (prev_addr_reg == cur_addr_reg);
   assign gap_bus.next_write = cur_write_reg;
   assign gap_bus.next_res   = cur_res_reg;

   hasp_gap_lookup u_lookup (
      .g (gap_bus.lookup)
   );

   // pin data passes two flops before anything reads it
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_sync1_reg <= '0;
         rd_sync2_reg <= '0;
      end else begin
         rd_sync1_reg <= i_bus_data;
         rd_sync2_reg <= rd_sync1_reg;
      end
   end

   assign gap_ok     = (elapsed_reg >= gap_bus.gap_cyc);
   assign strobe_end = (state_reg == ST_STROBE) && (strobe_reg == STROBE_CYC - 3'h1);
   assign launch_rd  = (state_reg == ST_WAIT) && !cur_write_reg && gap_ok;

   // next state, request capture, pins and answer
   always_comb begin
      state_next      = state_reg;
      strobe_next     = strobe_reg;
      probe_next      = probe_reg;
      cur_write_next  = cur_write_reg;
      cur_last_next   = cur_last_reg;
      cur_res_next    = cur_res_reg;
      cur_addr_next   = cur_addr_reg;
      cur_wdata_next  = cur_wdata_reg;
      prev_valid_next = prev_valid_reg;
      prev_write_next = prev_write_reg;
      prev_res_next   = prev_res_reg;
      prev_addr_next  = prev_addr_reg;
      resp_valid_next = 1'b0;
      resp_data_next  = resp_data_reg;
      // elapsed time saturates so long idles stay valid
      elapsed_next    = (elapsed_reg == GAP_MAX) ? elapsed_reg : elapsed_reg + 8'h01;
      unique case (state_reg)
         // take one request when ready
         ST_IDLE: begin
            if (i_req_valid) begin
               cur_write_next = i_req_write;
               cur_last_next  = i_req_last;
               cur_res_next   = i_req_res;
               cur_addr_next  = i_req_addr;
               cur_wdata_next = i_req_wdata;
               state_next     = ST_WAIT;
            end
         end
         // writes go at once; reads hold until the pair wait is met
         ST_WAIT: begin
            strobe_next = '0;
            if (cur_write_reg || gap_ok) begin
               probe_next = 1'b0;
               state_next = ST_STROBE;
            end else if (i_probe_mode) begin
               probe_next = 1'b1;
               state_next = ST_STROBE;
            end
         end
         // hold the strobe for its full length
         ST_STROBE: begin
            strobe_next = strobe_reg + 3'h1;
            if (strobe_end) begin
               if (probe_reg) begin
                  // dummy read burns time only; re-check the wait
                  state_next = ST_WAIT;
               end else begin
                  state_next      = ST_RECOVER;
                  resp_valid_next = !cur_write_reg;
                  resp_data_next  = rd_sync2_reg;
                  // only a dword-completing access starts a new wait
                  if (cur_last_reg) begin
                     prev_valid_next = 1'b1;
                     prev_write_next = cur_write_reg;
                     prev_res_next   = cur_res_reg;
                     prev_addr_next  = cur_addr_reg;
                     elapsed_next    = '0;
                  end
               end
            end
         end
         // one idle cycle between bus accesses
         ST_RECOVER: begin
            state_next = ST_IDLE;
         end
      endcase
      // pins follow the next state so they come straight from flops
      ready_next = (state_next == ST_IDLE);
      cs_n_next  = (state_next != ST_STROBE);
      rd_n_next  = !((state_next == ST_STROBE) && (probe_next || !cur_write_next));
      wr_n_next  = !((state_next == ST_STROBE) && !probe_next && cur_write_next);
      addr_next  = probe_next ? PROBE_ADDR : cur_addr_next;
      wdata_next = cur_wdata_next;
      oe_n_next  = wr_n_next;
   end

   // register all state
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg      <= ST_IDLE;
         strobe_reg     <= '0;
         probe_reg      <= 1'b0;
         cur_write_reg  <= 1'b0;
         cur_last_reg   <= 1'b0;
         cur_res_reg    <= RES_OTHER;
         cur_addr_reg   <= '0;
         cur_wdata_reg  <= '0;
         prev_valid_reg <= 1'b0;
         prev_write_reg <= 1'b0;
         prev_res_reg   <= RES_OTHER;
         prev_addr_reg  <= '0;
         elapsed_reg    <= GAP_MAX;
         ready_reg      <= 1'b0;
         resp_valid_reg <= 1'b0;
         resp_data_reg  <= '0;
         cs_n_reg       <= 1'b1;
         rd_n_reg       <= 1'b1;
         wr_n_reg       <= 1'b1;
         addr_reg       <= '0;
         wdata_reg      <= '0;
         oe_n_reg       <= 1'b1;
      end else begin
         state_reg      <= state_next;
         strobe_reg     <= strobe_next;
         probe_reg      <= probe_next;
         cur_write_reg  <= cur_write_next;
         cur_last_reg   <= cur_last_next;
         cur_res_reg    <= cur_res_next;
         cur_addr_reg   <= cur_addr_next;
         cur_wdata_reg  <= cur_wdata_next;
         prev_valid_reg <= prev_valid_next;
         prev_write_reg <= prev_write_next;
         prev_res_reg   <= prev_res_next;
         prev_addr_reg  <= prev_addr_next;
         elapsed_reg    <= elapsed_next;
         ready_reg      <= ready_next;
         resp_valid_reg <= resp_valid_next;
         resp_data_reg  <= resp_data_next;
         cs_n_reg       <= cs_n_next;
         rd_n_reg       <= rd_n_next;
         wr_n_reg       <= wr_n_next;
         addr_reg       <= addr_next;
         wdata_reg      <= wdata_next;
         oe_n_reg       <= oe_n_next;
      end
   end

   // outputs
   assign o_req_ready     = ready_reg;
   assign o_resp_valid    = resp_valid_reg;
   assign o_resp_data     = resp_data_reg;
   assign o_bus_cs_n      = cs_n_reg;
   assign o_bus_rd_n      = rd_n_reg;
   assign o_bus_wr_n      = wr_n_reg;
   assign o_bus_addr      = addr_reg;
   assign o_bus_data      = wdata_reg;
   assign o_bus_data_oe_n = oe_n_reg;

   // checks on the spacing of real reads and on the bus strobes
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);

   // helpers: a read of the given pair is about to launch
   logic after_wr;
   logic after_rd;
   assign after_wr = launch_rd && prev_valid_reg && prev_write_reg;
   assign after_rd = launch_rd && prev_valid_reg && !prev_write_reg;

   rxcfg_wait_a: assert property (
      after_wr && prev_res_reg == RES_RX_CFG && cur_res_reg == RES_IRQ_CFG
      |-> elapsed_reg >= RXCFG_IRQ_CYC)
      else $error("read of irq config too soon after rx config write");
   pwr_wait_a: assert property (
      after_wr && prev_res_reg == RES_PWR_CTRL && cur_res_reg == RES_PWR_CTRL
      |-> elapsed_reg >= PWR_SELF_CYC && elapsed_reg >= PWR_TOP_CYC)
      else $error("power control read back too soon");
   gpt_wait_a: assert property (
      after_wr && prev_res_reg == RES_GP_TIMER_CONFIG_REG && cur_res_reg == RES_GP_TIMER_COUNT_REG
      |-> elapsed_reg >= GP_TIMER_COUNT_REG_CYC)
      else $error("timer count read too soon after timer config write");
   ptp_cmd_wait_a: assert property (
      after_wr && prev_res_reg == RES_PTP_CMD && cur_res_reg == RES_PTP_STS
      |-> elapsed_reg >= PTP_STS_CYC)
      else $error("ptp status read too soon after ptp command write");
   evt_irq_wait_a: assert property (
      after_wr && cur_res_reg == RES_IRQ_CFG
      && (prev_res_reg == RES_PTP_STS || prev_res_reg == RES_PTP_EN || prev_res_reg == RES_PIN_EVT)
      |-> elapsed_reg >= PTP_EVT_CYC)
      else $error("irq config read too soon after event register write");
   queue_wait_a: assert property (
      after_rd && (cur_res_reg == RES_RX_QINFO || cur_res_reg == RES_TX_QINFO)
      && (prev_res_reg == RES_RX_DATA || prev_res_reg == RES_RX_STS || prev_res_reg == RES_TX_STS)
      |-> elapsed_reg >= QUEUE_CYC)
      else $error("queue info read too soon after fifo pop");
   drop_wait_a: assert property (
      after_rd && prev_res_reg == RES_RX_DROP && cur_res_reg == RES_RX_DROP
      |-> elapsed_reg >= DROP_CYC)
      else $error("drop counter reread too soon");
   same_reg_wait_a: assert property (
      after_wr && prev_addr_reg == cur_addr_reg |-> elapsed_reg >= ANY_WR_CYC)
      else $error("register read back too soon after write");
   partial_hold_a: assert property (
      strobe_end && !probe_reg && !cur_last_reg
      |=> $stable(prev_res_reg) && $stable(prev_addr_reg) && elapsed_reg != '0)
      else $error("partial access restarted the wait");
   probe_addr_a: assert property (
      $fell(o_bus_cs_n) && probe_reg |-> o_bus_addr == PROBE_ADDR && !o_bus_rd_n && o_bus_wr_n)
      else $error("probe strobe not a read of the probe address");
   strobe_len_a: assert property (
      $fell(o_bus_cs_n) |-> !o_bus_cs_n [*4] ##1 o_bus_cs_n)
      else $error("bus strobe length wrong");
   rxcfg_top_wait_a: assert property (
      after_wr && prev_res_reg == RES_RX_CFG && cur_res_reg == RES_TOP_STS
      |-> elapsed_reg >= RXCFG_TOP_CYC)
      else $error("status read too soon after rx config write");
   pwr_irq_wait_a: assert property (
      after_wr && prev_res_reg == RES_PWR_CTRL && cur_res_reg == RES_IRQ_CFG
      |-> elapsed_reg >= PWR_IRQ_CYC)
      else $error("irq config read too soon after power write");
   gpt_self_wait_a: assert property (
      after_wr && prev_res_reg == RES_GP_TIMER_CONFIG_REG && cur_res_reg == RES_GP_TIMER_CONFIG_REG
      |-> elapsed_reg >= GPT_SELF_CYC)
      else $error("timer config read back too soon");
   ptp_irq_wait_a: assert property (
      after_wr && prev_res_reg == RES_PTP_CMD && cur_res_reg == RES_IRQ_CFG
      |-> elapsed_reg >= PTP_IRQ_CYC)
      else $error("irq config read too soon after ptp command write");
   // writes never stall: the strobe follows the wait state at once
   write_go_a: assert property (
      state_reg == ST_WAIT && cur_write_reg |=> !o_bus_cs_n && !o_bus_wr_n)
      else $error("write strobe held back");

   // main scenarios
   wr_then_rd_c: cover property (after_wr && gap_bus.gap_cyc != '0);
   probe_fill_c: cover property ($fell(o_bus_cs_n) && probe_reg);
   pop_then_info_c: cover property (after_rd && cur_res_reg == RES_RX_QINFO);
   partial_c: cover property (strobe_end && !probe_reg && !cur_last_reg);
   probe_done_c: cover property (state_reg == ST_WAIT && probe_reg && gap_ok);
endmodule

//--- hasp_dev_model.sv
`timescale 1ns/1ps
// device model: a small register file behind the parallel host pins
module hasp_dev_model (
   // clock
   input  wire logic                        i_ref_clk,
   // host pins
   input  wire logic                        i_cs_n,
   input  wire logic                        i_rd_n,
   input  wire logic                        i_wr_n,
   input  wire logic [hasp_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [hasp_pkg::DATA_W-1:0] i_wdata,
   output logic      [hasp_pkg::DATA_W-1:0] o_rdata
);
   import hasp_pkg::*;
   logic [DATA_W-1:0] mem [16]; // register contents
   logic [DATA_W-1:0] last_reg; // last level seen on the data lines
   // power-up contents
   initial begin
      foreach (mem[i]) mem[i] = '0;
      last_reg = '0;
   end
   // a write takes effect at once, well inside every host wait
   always @(posedge i_ref_clk) begin
      if (!i_cs_n && !i_wr_n) begin
         mem[i_addr[5:2]] <= i_wdata;
      end
      last_reg <= o_rdata;
   end
   // released lines toggle, so stale data never looks valid
   assign o_rdata = (!i_cs_n && !i_rd_n) ? mem[i_addr[5:2]] : ~last_reg;
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
// bench for the spacing sequencer against a device model
module tb_top;
   import hasp_pkg::*;
   logic              clk, rst_n, valid, wr, last, probe, ready, rvalid;
   logic              cs_n, rd_n, wr_n, oe_n, cur_w, cur_l, rec_v, rec_w, cs_q;
   hasp_res_t         res, cur_r, rec_r;
   logic [ADDR_W-1:0] addr, bus_addr, rec_a, a_q;
   logic [DATA_W-1:0] wdata, rdata, pin_in, pin_out, dev_out;
   logic [DATA_W-1:0] shadow [16]; // expected register contents
   time               rec_t;       // end of last completing access
   int                fails, n_compared, seed, lat, lat0;
   hasp_res_t ta [18] = '{RES_RX_CFG, RES_RX_CFG, RES_PWR_CTRL, RES_PWR_CTRL, RES_PWR_CTRL,
      RES_GP_TIMER_CONFIG_REG, RES_GP_TIMER_CONFIG_REG, RES_PTP_CMD, RES_PTP_CMD, RES_PTP_CMD, RES_PTP_STS, RES_PTP_EN,
      RES_PIN_EVT, RES_OTHER, RES_RX_DATA, RES_RX_STS, RES_TX_STS, RES_RX_DROP};
   hasp_res_t tn [18] = '{RES_IRQ_CFG, RES_TOP_STS, RES_PWR_CTRL, RES_IRQ_CFG, RES_TOP_STS,
      RES_GP_TIMER_CONFIG_REG, RES_GP_TIMER_COUNT_REG, RES_IRQ_CFG, RES_TOP_STS, RES_PTP_STS, RES_IRQ_CFG, RES_IRQ_CFG,
      RES_IRQ_CFG, RES_OTHER, RES_RX_QINFO, RES_RX_QINFO, RES_TX_QINFO, RES_RX_DROP};
   // host drives the data lines while its enable is low
   assign pin_in = !oe_n ? pin_out : dev_out;
   hasp_seq hasp_seq_inst (.i_ref_clk(clk), .i_reset_n(rst_n), .i_req_valid(valid), .i_req_write(wr),
      .i_req_last(last), .i_req_res(res), .i_req_addr(addr), .i_req_wdata(wdata), .i_probe_mode(probe),
      .o_req_ready(ready), .o_resp_valid(rvalid), .o_resp_data(rdata), .o_bus_cs_n(cs_n),
      .o_bus_rd_n(rd_n), .o_bus_wr_n(wr_n), .o_bus_addr(bus_addr), .i_bus_data(pin_in),
      .o_bus_data(pin_out), .o_bus_data_oe_n(oe_n));
   hasp_dev_model hasp_dev_model_inst (.i_ref_clk(clk), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_addr(bus_addr), .i_wdata(pin_out), .o_rdata(dev_out));
   // address of each resource class
   function automatic logic [ADDR_W-1:0] adr(hasp_res_t r);
      return 16'h0100 | {9'h000, r, 2'b00};
   endfunction
   // least gap in ns between the recorded access and a read of n
   function automatic int need_ns(logic pw, hasp_res_t p, hasp_res_t n, logic same);
      int t;
      t = (pw && same) ? 45 : 0;
      if (pw) begin
         case (p)
            RES_RX_CFG:   t = (n == RES_IRQ_CFG) ? 80 : (n == RES_TOP_STS) ? 60 : t;
            RES_PWR_CTRL: t = (n == RES_PWR_CTRL) ? 165 : (n == RES_IRQ_CFG) ? 170 : (n == RES_TOP_STS) ? 160 : t;
            RES_GP_TIMER_CONFIG_REG:  t = (n == RES_GP_TIMER_CONFIG_REG) ? 55 : (n == RES_GP_TIMER_COUNT_REG) ? 170 : t;
            RES_PTP_CMD:  t = (n == RES_IRQ_CFG) ? 70 : (n == RES_TOP_STS || n == RES_PTP_STS) ? 50 : t;
            RES_PTP_STS, RES_PTP_EN, RES_PIN_EVT: t = (n == RES_IRQ_CFG) ? 60 : t;
            default: ;
         endcase
      end else if (((p == RES_RX_DATA || p == RES_RX_STS) && n == RES_RX_QINFO) || (p == RES_TX_STS && n == RES_TX_QINFO)) begin
         t = 135;
      end else if (p == RES_RX_DROP && n == RES_RX_DROP) begin
         t = 180;
      end
      return t;
   endfunction
   // one whole access; returns once the sequencer is idle again
   task automatic acc(input logic w, input logic l, input hasp_res_t r, input logic pm);
      logic [DATA_W-1:0] d;
      int                k;
      d = 16'($random(seed));
      @(posedge clk);
      cur_w = w;
      cur_l = l;
      cur_r = r;
      valid <= 1'b1;
      wr <= w;
      last <= l;
      res <= r;
      addr <= adr(r);
      wdata <= d;
      probe <= pm;
      k = 0;
      do begin @(posedge clk); k++; end while (!ready && k < 300);
      valid <= 1'b0;
      if (w) shadow[r[3:0]] = d;
      k = 0;
      do begin @(posedge clk); k++; end while (!(w ? ready : rvalid) && k < 300);
      lat = k;
      if (w) `CHK(ready, 1'b1)
      if (!w) begin
         `CHK(rvalid, 1'b1)
         `CHK(rdata, shadow[r[3:0]])
         do @(posedge clk); while (!ready && k++ < 300);
      end
   endtask
   // watch the pins: read strobes must keep the pair's distance
   always @(posedge clk) begin
      if (!rst_n) rec_v = 1'b0;
      if (cs_q && !cs_n && !rd_n && bus_addr != PROBE_ADDR && rec_v)
         `CHK(($time - rec_t) >= need_ns(rec_w, rec_r, cur_r, rec_a == bus_addr), 1'b1)
      if (!cs_q && cs_n && a_q != PROBE_ADDR && cur_l) begin
         rec_v = 1'b1;
         rec_t = $time;
         rec_w = cur_w;
         rec_r = cur_r;
         rec_a = a_q;
      end
      if (!cs_n) a_q = bus_addr;
      cs_q = cs_n;
   end
   // verdict and end of run
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   initial begin
      #200000;
      fails++;
      wrap_up();
   end
   // main sequence
   initial begin
      seed = 15140;
      {rst_n, valid, wr, last, probe, cur_w, cur_l, rec_v, cs_q} = '0;
      {addr, wdata, a_q} = '0;
      res = RES_OTHER;
      cur_r = RES_OTHER;
      foreach (shadow[i]) shadow[i] = '0;
      repeat (10) @(posedge clk);
      `CHK(ready, 1'b0) // reset state
      `CHK(cs_n, 1'b1) // idle pins in reset
      rst_n <= 1'b1;
      // every listed pair, waits and probe fill alternating
      for (int i = 0; i < 18; i++) begin
         acc(i < 14, 1'b1, ta[i], i[0]);
         acc(1'b0, 1'b1, tn[i], i[0]);
      end
      // partial word write arms no wait
      repeat (30) @(posedge clk);
      acc(1'b0, 1'b1, RES_OTHER, 1'b0);
      lat0 = lat;
      acc(1'b1, 1'b0, RES_PWR_CTRL, 1'b0);
      acc(1'b0, 1'b1, RES_PWR_CTRL, 1'b0);
      `CHK(lat, lat0)
      // random traffic
      repeat (80) acc(1'($random(seed)), |2'($random(seed)), hasp_res_t'(4'($random(seed))), 1'($random(seed)));
      wrap_up();
   end
endmodule
